// File: rtl/ssf_status.v
// Purpose: Status flags and multiprocessor bits of a serial channel, AXI4-Lite slave.
// Assumes: Shifters, mode register and bit-rate logic sit outside and give strobes.
// Notes:   Strobes are one-cycle pulses on aclk.
//
// Contract
// [R01] Software clears error and data flags only by read-1-write-0.
// [R02] Status resets to 84 on reset, standby, stop.
// [R03] Transmit end and received MP bit read-only.
// [R04] Transmit empty sets when disabled or on load.
// [R05] Transmit empty clears on write-0 or DMA write.
// [R06] Receive full sets on clean completed reception.
// [R07] Receive full clears on write-0 or DMA read.
// [R08] Errors and disable keep holding data and full.
// [R09] Reception while full sets overrun, drops byte.
// [R10] Error flags stop reception, synchronous transmission too.
// [R11] Receive disable keeps error flags.
// [R12] First stop bit zero sets framing error.
// [R13] Framing or parity error still stores byte.
// [R14] Parity mismatch sets parity error when enabled.
// [R15] Transmit end sets when disabled or empty at end.
// [R16] Transmit end clears with transmit empty.
// [R17] Received MP bit stored, kept on disable.
// [R18] Transmit MP bit used only in async MP format.
// [R19] Software may access status at any time.
// [R20] Receive interrupts gated by receive interrupt enable.
// [R21] MP bit one clears MP interrupt enable.
// [R22] Transmit empty interrupt needs flag and enable.
// [R23] Read-one tracking per flag; hardware set wins.
`timescale 1ns/1ns
`default_nettype none
`include "ssf_regs.vh"
module ssf_status
(
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // Power state.
  input  wire        standby,
  input  wire        module_stop,
  // AXI4-Lite write.
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read.
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Mode from the mode register.
  input  wire        sync_mode,
  input  wire        mp_format,
  // Transmitter side.
  input  wire        tx_load,
  input  wire        tx_last_bit,
  input  wire        dma_tx_write,
  output reg         tx_mp_out,
  output wire        tx_allowed,
  // Receiver side.
  input  wire        rx_done,
  input  wire [7:0]  rx_shift_reg,
  input  wire        rx_parity_bit,
  input  wire        rx_stop_bit,
  input  wire        rx_mp_in,
  input  wire        dma_rx_read,
  output wire        rx_allowed,
  // Interrupt requests and enables.
  output wire        tx_empty_irq,
  output wire        tx_done_irq,
  output wire        rx_full_irq,
  output wire        rx_error_irq,
  output wire        transmit_enable,
  output wire        receive_enable
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  reg  [7:0] status;
  reg  [7:0] control;
  reg  [7:0] rx_holding_reg;
  reg  [7:0] seen_one;
  wire       init = !aresetn || standby || module_stop;

  wire tx_holding_empty = status[`SSF_BIT_TDE];
  wire rx_holding_full  = status[`SSF_BIT_RDF];
  wire overrun_error    = status[`SSF_BIT_ORE];
  wire framing_error    = status[`SSF_BIT_FRE];
  wire parity_error     = status[`SSF_BIT_PRE];
  wire transmit_end     = status[`SSF_BIT_TRANSMIT_END];
  wire any_error        = overrun_error | framing_error | parity_error;

  assign transmit_enable = control[`SSF_CTL_TE];
  assign receive_enable  = control[`SSF_CTL_RE];
  wire   multiproc_irq_enable = control[`SSF_CTL_MULTIPROC_IRQ_ENABLE];

  // ----------------------------------------------------------------
  // Bus handshake: both write channels taken together.
  // ----------------------------------------------------------------
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  wire wr_status = wr_go && s_axi_awaddr == `SSF_OFF_STATUS && s_axi_wstrb[0];
  wire wr_ctrl   = wr_go && s_axi_awaddr == `SSF_OFF_CONTROL && s_axi_wstrb[0];
  wire rd_status = rd_go && s_axi_araddr == `SSF_OFF_STATUS;
  wire [7:0] wbyte = s_axi_wdata[7:0];

  // ----------------------------------------------------------------
  // Receive evaluation.
  // ----------------------------------------------------------------
  wire mp_skip   = mp_format && !sync_mode && multiproc_irq_enable && !rx_mp_in;
  wire rx_take   = rx_done && receive_enable && !any_error && !mp_skip; // [R10]
  wire par_bad   = !sync_mode && control[`SSF_CTL_PE] &&
                   ((^rx_shift_reg ^ rx_parity_bit) != control[`SSF_CTL_ODD]); // [R14]
  wire frm_bad   = !sync_mode && !rx_stop_bit; // [R12]
  wire ovr       = rx_take && rx_holding_full; // [R09]
  wire rx_clean  = rx_take && !rx_holding_full && !par_bad && !frm_bad; // [R06]
  wire rx_store  = rx_take && !rx_holding_full; // [R13]

  assign rx_allowed = receive_enable && !any_error; // [R10]
  assign tx_allowed = transmit_enable && !(sync_mode && any_error); // [R10]

  // ----------------------------------------------------------------
  // Software clears: a 0 written over a flag that was read as 1.
  // ----------------------------------------------------------------
  wire sw_clr_tde = wr_status && seen_one[`SSF_BIT_TDE] && !wbyte[`SSF_BIT_TDE]; // [R01] [R23]
  wire sw_clr_rdf = wr_status && seen_one[`SSF_BIT_RDF] && !wbyte[`SSF_BIT_RDF]; // [R01] [R23]
  wire sw_clr_ore = wr_status && seen_one[`SSF_BIT_ORE] && !wbyte[`SSF_BIT_ORE]; // [R01] [R23]
  wire sw_clr_fre = wr_status && seen_one[`SSF_BIT_FRE] && !wbyte[`SSF_BIT_FRE]; // [R01] [R23]
  wire sw_clr_pre = wr_status && seen_one[`SSF_BIT_PRE] && !wbyte[`SSF_BIT_PRE]; // [R01] [R23]

  // ----------------------------------------------------------------
  // Clear and set terms of each flag.
  // ----------------------------------------------------------------
  wire clr_tde  = sw_clr_tde || dma_tx_write; // [R05]
  wire clr_rdf  = sw_clr_rdf || dma_rx_read; // [R07]
  wire clr_transmit_end = clr_tde; // [R16]
  wire set_tde  = !transmit_enable || tx_load; // [R04]
  wire set_rdf  = rx_clean; // [R06]
  wire set_ore  = ovr; // [R09]
  wire set_fre  = rx_store && frm_bad; // [R12]
  wire set_pre  = rx_store && par_bad; // [R14]
  wire set_transmit_end = !transmit_enable || (tx_last_bit && tx_holding_empty); // [R15]
  wire load_rmp = rx_take && mp_format && !sync_mode; // [R17]

  // ----------------------------------------------------------------
  // Next value of each flag; a hardware set beats a clear.
  // ----------------------------------------------------------------
  reg next_tde;
  reg next_rdf;
  reg next_ore;
  reg next_fre;
  reg next_pre;
  reg next_transmit_end;
  reg next_rmp;
  reg next_tmp;

  always @*
  begin
    next_tde = tx_holding_empty;
    if (clr_tde)
      next_tde = 1'b0;
    if (set_tde)
      next_tde = 1'b1; // [R23]
  end

  always @*
  begin
    next_rdf = rx_holding_full;
    if (clr_rdf)
      next_rdf = 1'b0;
    if (set_rdf)
      next_rdf = 1'b1; // [R23]
  end

  always @*
  begin
    next_ore = overrun_error; // [R11]
    if (sw_clr_ore)
      next_ore = 1'b0;
    if (set_ore)
      next_ore = 1'b1; // [R23]
  end

  always @*
  begin
    next_fre = framing_error; // [R11]
    if (sw_clr_fre)
      next_fre = 1'b0;
    if (set_fre)
      next_fre = 1'b1; // [R23]
  end

  always @*
  begin
    next_pre = parity_error; // [R11]
    if (sw_clr_pre)
      next_pre = 1'b0;
    if (set_pre)
      next_pre = 1'b1; // [R23]
  end

  always @*
  begin
    next_transmit_end = transmit_end;
    if (clr_transmit_end)
      next_transmit_end = 1'b0;
    if (set_transmit_end)
      next_transmit_end = 1'b1; // [R23]
  end

  always @*
  begin
    next_rmp = status[`SSF_BIT_RMP];
    if (load_rmp)
      next_rmp = rx_mp_in; // [R17]
  end

  always @*
  begin
    next_tmp = status[`SSF_BIT_TMP];
    if (wr_status)
      next_tmp = wbyte[`SSF_BIT_TMP];
  end

  wire [7:0] next_status = {next_tde, next_rdf, next_ore, next_fre,
                            next_pre, next_transmit_end, next_rmp, next_tmp}; // [R03]

  always @(posedge aclk)
  begin
    if (init)
      status <= `SSF_STATUS_RESET; // [R02]
    else
      status <= next_status;
  end

  // ----------------------------------------------------------------
  // Read-one tracking: armed by a status read, ended by a status write.
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (init)
      seen_one <= 8'h00;
    else if (rd_status)
      seen_one <= status & 8'hf8; // [R23]
    else if (wr_status)
      seen_one <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Control register and holding data.
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (init)
    begin
      control        <= `SSF_CONTROL_RESET;
      rx_holding_reg <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        control <= wbyte;
      else if (rx_take && mp_format && !sync_mode && rx_mp_in)
        control[`SSF_CTL_MULTIPROC_IRQ_ENABLE] <= 1'b0; // [R21]
      if (rx_store)
        rx_holding_reg <= rx_shift_reg; // [R08]
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      tx_mp_out <= 1'b0;
    else
      tx_mp_out <= mp_format && !sync_mode && transmit_enable && status[`SSF_BIT_TMP]; // [R18]
  end

  // ----------------------------------------------------------------
  // Interrupt requests.
  // ----------------------------------------------------------------
  assign tx_empty_irq = tx_holding_empty && control[`SSF_CTL_TIE]; // [R22]
  assign tx_done_irq  = transmit_end && control[`SSF_CTL_TX_DONE_IRQ_ENABLE];
  assign rx_full_irq  = rx_holding_full && control[`SSF_CTL_RIE]; // [R20]
  assign rx_error_irq = any_error && control[`SSF_CTL_RIE]; // [R20]

  // ----------------------------------------------------------------
  // Response decode: unmapped offsets answer with an error.
  // ----------------------------------------------------------------
  reg [1:0]  next_bresp;
  reg [1:0]  next_rresp;
  reg [31:0] next_rdata;

  always @*
  begin
    next_bresp = `SSF_RESP_SLVERR;
    case (s_axi_awaddr)
      `SSF_OFF_STATUS:
      begin
        next_bresp = `SSF_RESP_OKAY;
      end
      `SSF_OFF_CONTROL:
      begin
        next_bresp = `SSF_RESP_OKAY;
      end
      default:
      begin
        next_bresp = `SSF_RESP_SLVERR;
      end
    endcase
  end

  always @*
  begin
    next_rresp = `SSF_RESP_OKAY;
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr)
      `SSF_OFF_STATUS:
      begin
        next_rresp = `SSF_RESP_OKAY;
        next_rdata = {24'h000000, status}; // [R19]
      end
      `SSF_OFF_CONTROL:
      begin
        next_rresp = `SSF_RESP_OKAY;
        next_rdata = {24'h000000, control};
      end
      `SSF_OFF_RXDATA:
      begin
        next_rresp = `SSF_RESP_OKAY;
        next_rdata = {24'h000000, rx_holding_reg};
      end
      default:
      begin
        next_rresp = `SSF_RESP_SLVERR;
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus responses.
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SSF_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `SSF_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end
    else
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= next_bresp;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= next_rresp;
        s_axi_rdata  <= next_rdata; // [R19]
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: rtl/ssf_regs.vh
// Purpose: Register offsets, field positions and reset values of the status flag block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus.
// Notes:   Definitions only.
`ifndef SSF_REGS_VH
`define SSF_REGS_VH
`define SSF_ADDR_W        4
`define SSF_OFF_STATUS    4'h0
`define SSF_OFF_CONTROL   4'h4
`define SSF_OFF_RXDATA    4'h8
`define SSF_STATUS_RESET  8'h84
`define SSF_CONTROL_RESET 8'h00
`define SSF_BIT_TDE       7
`define SSF_BIT_RDF       6
`define SSF_BIT_ORE       5
`define SSF_BIT_FRE       4
`define SSF_BIT_PRE       3
`define SSF_BIT_TRANSMIT_END      2
`define SSF_BIT_RMP       1
`define SSF_BIT_TMP       0
`define SSF_CTL_TIE       7
`define SSF_CTL_RIE       6
`define SSF_CTL_TE        5
`define SSF_CTL_RE        4
`define SSF_CTL_MULTIPROC_IRQ_ENABLE      3
`define SSF_CTL_TX_DONE_IRQ_ENABLE      2
`define SSF_CTL_PE        1
`define SSF_CTL_ODD       0
`define SSF_RESP_OKAY     2'b00
`define SSF_RESP_SLVERR   2'b10
`endif

// File: verification/ssf_status_chk.sv
// Purpose: Port checks of ssf_status.
// Assumes: aresetn synchronous, active low.
// Notes:   Bound after the module.
`timescale 1ns/1ns
`default_nettype none
module ssf_status_chk (
  // Watched ports.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  input wire logic module_stop,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync_mode,
  input wire logic mp_format,
  input wire logic tx_allowed,
  input wire logic rx_allowed,
  input wire logic rx_error_irq,
  input wire logic transmit_enable,
  input wire logic tx_mp_out
);
  // ----------
  // Checks.
  // ----------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_ans_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("no write answer");
  rd_ans_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("no read answer");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
  err_rx_a: assert property (rx_error_irq |-> !rx_allowed)
    else $error("receive during error");
  err_tx_a: assert property (sync_mode && rx_error_irq |-> !tx_allowed)
    else $error("send during error");
  err_keep_a: assert property (rx_error_irq && !s_axi_awvalid && !standby
    && !module_stop |=> rx_error_irq) else $error("error flag lost");
  reset_init_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid
    && !s_axi_rvalid && !transmit_enable) else $error("reset state wrong");
  tmp_gate_a: assert property (!mp_format || sync_mode || !transmit_enable |=> !tx_mp_out)
    else $error("multiprocessor bit outside its format");
  cover property (sync_mode && rx_error_irq);
  cover property (s_axi_rvalid && !transmit_enable);
  cover property (standby);
endmodule
bind ssf_status ssf_status_chk u_ssf_status_chk (.*);
`default_nettype wire

// File: verification/ssf_far_end.sv
// Purpose: Far transceiver model giving frame strobes.
// Assumes: Load strobe needs tx_allowed at frame start, done strobe needs rx_allowed at frame end.
// Notes:   Frame length follows the low data bits.
`timescale 1ns/1ns
`default_nettype none
module ssf_far_end (
  // Bench and channel side.
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic        tx_go,
  input  wire logic [10:0] fr,
  input  wire logic        rx_allowed,
  input  wire logic        tx_allowed,
  output logic             busy = 1'b0,
  output logic             rx_done = 1'b0,
  output logic             tx_load = 1'b0,
  output logic             tx_last_bit = 1'b0,
  output logic [10:0]      line = 11'h0
);
  logic [10:0] hold;
  logic [3:0]  cnt;
  logic        txm;
  always @(posedge aclk)
  begin
    rx_done <= 1'b0;
    tx_load <= 1'b0;
    tx_last_bit <= 1'b0;
    line <= ~line;
    if ((go || tx_go) && !busy)
    begin
      busy <= 1'b1;
      hold <= fr;
      txm <= tx_go;
      cnt <= {1'b0, fr[2:0]} + 4'h1;
      tx_load <= tx_go && tx_allowed;
    end
    else if (busy)
    begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1)
      begin
        busy <= 1'b0;
        tx_last_bit <= txm;
        rx_done <= !txm && rx_allowed;
        if (!txm)
          line <= hold;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/test_ssf_status.sv
// Purpose: Self-checking bench of ssf_status.
// Assumes: Far end modelled by ssf_far_end.
// Notes:   Each read queues its expected word.
`timescale 1ns/1ns
`default_nettype none
module test_ssf_status;
  logic        aclk, aresetn, standby, module_stop, sync_mode, mp_format, go, tx_go;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        dma_tx_write, dma_rx_read, busy, rx_done, tx_load, tx_last_bit;
  logic        tx_allowed, rx_allowed;
  logic [3:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [10:0] fr, line;
  logic [7:0]  b;
  logic [33:0] exp_q[$];
  int          error_cnt, cmp_count, cyc, o;
  int          seed = 32'h2a46c7e2;
  ssf_status u_ssf_status (.*, .tx_mp_out(), .tx_empty_irq(), .tx_done_irq(), .rx_full_irq(),
    .rx_error_irq(), .transmit_enable(), .receive_enable(), .rx_shift_reg(line[7:0]),
    .rx_parity_bit(line[8]), .rx_stop_bit(line[9]), .rx_mp_in(line[10]));
  ssf_far_end u_ssf_far_end (.*);
  // ----------
  // Bus tasks and checking.
  // ----------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge aclk iff (s_axi_awready && s_axi_wready));
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(negedge aclk iff s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge aclk iff s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(negedge aclk iff s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic frame(input logic t, input logic [10:0] f);
    fr <= f;
    go <= !t;
    tx_go <= t;
    @(posedge aclk);
    go <= 1'b0;
    tx_go <= 1'b0;
    do @(posedge aclk); while (busy);
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] e);
    cmp_count++;
    if (got !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, e);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ----------
  // Scenarios.
  // ----------
  initial
  begin
    {aresetn, standby, module_stop, sync_mode, mp_format, go, tx_go, dma_tx_write} = '0;
    {dma_rx_read, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fr} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0, 34'h84);
    rd(4'h4, 34'h0);
    rd(4'hc, 34'h200000000);
    wr(4'h0, 8'hff);
    rd(4'h0, 34'h85);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h70);
    wr(4'h0, 8'h00);
    rd(4'h0, 34'h84);
    wr(4'h0, 8'h00);
    rd(4'h0, 34'h00);
    frame(1'b1, 11'h0);
    rd(4'h0, 34'h84);
    dma_tx_write <= 1'b1;
    @(posedge aclk);
    dma_tx_write <= 1'b0;
    rd(4'h0, 34'h00);
    $display("transmit test end");
    b = $random(seed);
    frame(1'b0, {3'b010, b});
    rd(4'h0, 34'h40);
    sync_mode <= 1'b1;
    frame(1'b0, {3'b010, ~b});
    rd(4'h0, 34'h60);
    rd(4'h8, {26'h0, b});
    wr(4'h0, 8'h00);
    sync_mode <= 1'b0;
    b = $random(seed);
    frame(1'b0, {3'b000, b});
    rd(4'h0, 34'h10);
    rd(4'h8, {26'h0, b});
    wr(4'h0, 8'h00);
    for (o = 0; o < 2; o++)
    begin
      b = $random(seed);
      wr(4'h4, {7'h39, o[0]});
      frame(1'b0, {2'b01, ^b ^ !o[0], b});
      rd(4'h0, 34'h08);
      wr(4'h0, 8'h00);
      frame(1'b0, {2'b01, ^b ^ o[0], b});
      rd(4'h0, 34'h40);
      dma_rx_read <= 1'b1;
      @(posedge aclk);
      dma_rx_read <= 1'b0;
      rd(4'h0, 34'h00);
    end
    $display("receive test end");
    wr(4'h4, 8'h70);
    mp_format <= 1'b1;
    frame(1'b0, {3'b110, b});
    rd(4'h0, 34'h42);
    dma_rx_read <= 1'b1;
    @(posedge aclk);
    dma_rx_read <= 1'b0;
    wr(4'h4, 8'h78);
    frame(1'b0, {3'b010, ~b});
    rd(4'h0, 34'h02);
    rd(4'h8, {26'h0, b});
    frame(1'b0, {3'b110, ~b});
    rd(4'h4, 34'h70);
    wr(4'h4, 8'h40);
    rd(4'h0, 34'hc6);
    standby <= 1'b1;
    @(posedge aclk);
    standby <= 1'b0;
    rd(4'h0, 34'h84);
    wr(4'h0, 8'h01);
    module_stop <= 1'b1;
    @(posedge aclk);
    module_stop <= 1'b0;
    rd(4'h0, 34'h84);
    $display("power test end");
    @(posedge aclk);
    end_of_test();
  end
endmodule
`default_nettype wire
